/* common/edge_timing_defines.svh */
// offsets, field codes, reset values and timing counts for the edge timer block
`ifndef EDGE_TIMING_DEFINES_SVH
`define EDGE_TIMING_DEFINES_SVH

// clock rate of ref_clk, the core clock of the block
`define CORE_CLK_HZ        200000000
`define CLK_PERIOD_NS      5
// shortest interval the line timer must resolve
`define MIN_INTERVAL_NS    50
`define MIN_INTERVAL_CYC   ((`MIN_INTERVAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// feature codes written to line_feature_select
`define FEAT_LINE_TIMER    32'h0000_0006
`define FEAT_HW_COUNT      32'h0000_0007
`define FEAT_FW_COUNT      32'h0000_0008

// register map: line page, line in addr[7:4], field in addr[3:0]
`define LINE_PAGE          8'h20
`define NUM_LINES          4'h7
`define NUM_TIMED          4'h2
`define FLD_ON             4'h0
`define FLD_SELECT         4'h1
`define FLD_CLOCK_PICK     4'h2
`define FLD_POLARITY       4'h3
`define FLD_TICKS          4'h4
`define FLD_SECONDS        4'h5
`define FLD_READ_CLEAR     4'h6
// tick source page: source in addr[3:2], field in addr[1:0]
`define TICK_PAGE          8'h21
`define NUM_TICK_SRC       2'h3
`define TFLD_DIVIDER       2'h0
`define TFLD_WRAP          2'h1
`define TFLD_ON            2'h2
`define STREAM_HI_ADDR     16'h2200
`define SYS_TIMER_ADDR     16'hF050

`define CFG_RESET          32'h0000_0000
`define DIV_RESET          9'h000
// 2^48 / CORE_CLK_HZ, turns ticks times divisor into seconds in Q16.16
`define SEC_SCALE          64'h0000_0000_0015_798E

`endif

/* common/edge_timing_pkg.sv */
// types shared by the edge counter and line timer block
package edge_timing_pkg;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        stream;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } reg_rsp_s;

  typedef struct packed {
    logic        on;
    logic [31:0] select;
    logic [2:0]  pick;
    logic        rising;
  } line_cfg_s;

  typedef enum logic [3:0] {
    TIMER_OFF         = 4'h1,
    TIMER_WAIT_FIRST  = 4'h2,
    TIMER_WAIT_SECOND = 4'h4,
    TIMER_DONE        = 4'h8
  } timer_state_e;

endpackage : edge_timing_pkg

/* logic/line_sampler.sv */
// two-flop synchroniser and edge detector for one input line
`timescale 1ns/1ps
`default_nettype none
module line_sampler (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // line
  input  wire logic line_in,
  output logic      rise,
  output logic      fall
);
  logic sync_a;
  logic sync_b;
  logic last;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
    end else begin
      sync_a <= line_in;
      sync_b <= sync_a;
      last   <= sync_b;
    end
  end

  assign rise = sync_b & ~last;
  assign fall = ~sync_b & last;
endmodule : line_sampler
`default_nettype wire

/* logic/edge_tally.sv */
// 32-bit rising-edge counter with read-and-clear
`timescale 1ns/1ps
`default_nettype none
module edge_tally (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // control
  input  wire logic        enable,
  input  wire logic        rise,
  input  wire logic        clear,
  // result
  output logic [31:0]      count
);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 32'h0000_0000;
    end else if (clear) begin
      // an edge in the clearing cycle is kept, not lost
      count <= {31'h0, enable & rise};
    end else if (enable && rise) begin
      count <= count + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_count_step;
    (enable && rise && !clear) |=> (count == $past(count) + 32'h0000_0001);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not advance by one on a rising edge");

  property p_clear_zero;
    (clear && !(enable && rise)) |=> (count == 32'h0000_0000) ##1 (count <= 32'h0000_0001);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("read-and-clear left a stale count");
endmodule : edge_tally
`default_nettype wire

/* logic/edge_counters_and_line_timer.sv */
// line-to-line timer, edge counters and system tick timer behind a register port
//
// Function
// - timer result reads zero until the configured edge pair is seen
// - timer result reads identically through either timed line
// - timer interval is also readable converted to seconds
// - timer read-and-clear returns result, zeroes it, arms a new measurement
// - wait for first-line edge, then second-line edge, store ticks between
// - intervals down to fifty nanoseconds are resolved
// - after capture, no new measurement until reconfigured or read-and-clear
// - edge polarity 0 means falling edge; clock pick 0 means tick source zero
// - feature on field: 0 turns feature off, 1 turns it on
// - up to four hardware counters count rising edges at high rate
// - counter result returns running count, plus one per rising edge
// - second counter blocked by tick sources zero/two; fourth by streaming
// - counter read-and-clear returns count then zeroes it
// - stream reads return low half; high half captured for same scan
// - free-running 32-bit system timer at half the core clock rate
// - firmware-serviced counter adds one per rising edge of its line
// - tick rate is core rate over divisor; time is ticks over that rate
// - each timed line independently picks rising or falling edge
`timescale 1ns/1ps
`include "edge_timing_defines.svh"
`default_nettype none
module edge_counters_and_line_timer import edge_timing_pkg::*; (
  // clock and reset
  input  wire logic      ref_clk,
  input  wire logic      resetn,
  // register port
  input  wire reg_req_s  reg_req,
  output var  reg_rsp_s  reg_rsp,
  // signal lines
  input  wire logic      first_timed_line,
  input  wire logic      second_timed_line,
  input  wire logic [3:0] hw_count_lines,
  input  wire logic      free_counter_pin,
  // streaming owns the fourth counter while high
  input  wire logic      stream_active
);

  // line order: timed pair, four hardware counters, firmware counter
  logic [6:0]   raw_lines;
  logic [6:0]   rise;
  logic [6:0]   fall;
  line_cfg_s    line_cfg [7];
  logic [8:0]   tick_div [3];
  logic [31:0]  tick_wrap [3];
  logic [2:0]   tick_on;
  logic [8:0]   tick_cnt [3];
  logic [8:0]   eff_div [3];
  logic [2:0]   tick;
  timer_state_e timer_state;
  logic [31:0]  timer_count;
  logic [31:0]  timer_result;
  logic [31:0]  timer_seconds;
  logic [31:0]  counts [5];
  logic [4:0]   cnt_en;
  logic [4:0]   tally_clear;
  logic [31:0]  sys_timer;
  logic         sys_phase;
  logic [31:0]  stream_hi;

  assign raw_lines = {free_counter_pin, hw_count_lines, second_timed_line, first_timed_line};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_line
      line_sampler u_sampler (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .line_in (raw_lines[gi]),
        .rise    (rise[gi]),
        .fall    (fall[gi])
      );
    end
  endgenerate

  // address decode
  logic [3:0]  req_line;
  logic [3:0]  req_field;
  logic        line_hit;
  logic        tick_hit;
  logic [1:0]  req_src;
  logic        line_wr;
  logic        rd_result;

  assign req_line  = reg_req.addr[7:4];
  assign req_field = reg_req.addr[3:0];
  assign req_src   = reg_req.addr[3:2];
  assign line_hit  = (reg_req.addr[15:8] == `LINE_PAGE) && (req_line < `NUM_LINES)
                     && (req_field <= `FLD_READ_CLEAR);
  assign tick_hit  = (reg_req.addr[15:8] == `TICK_PAGE) && (reg_req.addr[7:4] == 4'h0)
                     && (req_src < `NUM_TICK_SRC) && (reg_req.addr[1:0] <= `TFLD_ON);
  assign line_wr   = reg_req.wr && line_hit;
  assign rd_result = reg_req.rd && line_hit
                     && (req_field == `FLD_TICKS || req_field == `FLD_READ_CLEAR);

  // per-line configuration
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 7; i++) begin
        line_cfg[i] <= '0;
      end
    end else if (line_wr) begin
      case (req_field)
        `FLD_ON:         line_cfg[req_line[2:0]].on     <= reg_req.wdata[0];
        `FLD_SELECT:     line_cfg[req_line[2:0]].select <= reg_req.wdata;
        `FLD_CLOCK_PICK: line_cfg[req_line[2:0]].pick   <= reg_req.wdata[2:0];
        `FLD_POLARITY:   line_cfg[req_line[2:0]].rising <= reg_req.wdata[0];
        default: ;
      endcase
    end
  end

  // tick source configuration
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_on <= 3'h0;
      for (int s = 0; s < 3; s++) begin
        tick_div[s]  <= `DIV_RESET;
        tick_wrap[s] <= `CFG_RESET;
      end
    end else if (reg_req.wr && tick_hit) begin
      case (reg_req.addr[1:0])
        `TFLD_DIVIDER: tick_div[req_src]  <= reg_req.wdata[8:0];
        `TFLD_WRAP:    tick_wrap[req_src] <= reg_req.wdata;
        `TFLD_ON:      tick_on[req_src]   <= reg_req.wdata[0];
        default: ;
      endcase
    end
  end

  // tick sources: one pulse every divisor core cycles, divisor 0 acts as 1
  always_comb begin
    for (int s = 0; s < 3; s++) begin
      eff_div[s] = (tick_div[s] == 9'h000) ? 9'h001 : tick_div[s];
      tick[s]    = tick_on[s] && (tick_cnt[s] == eff_div[s] - 9'h001);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int s = 0; s < 3; s++) begin
        tick_cnt[s] <= 9'h000;
      end
    end else begin
      for (int s = 0; s < 3; s++) begin
        tick_cnt[s] <= (!tick_on[s] || tick[s]) ? 9'h000 : tick_cnt[s] + 9'h001;
      end
    end
  end

  // line-to-line timer
  logic        timer_cfg_ok;
  logic        timer_rearm;
  logic        first_edge;
  logic        second_edge;
  logic        src_tick;
  logic [1:0]  src_idx;
  logic        src_valid;
  logic [31:0] next_count;

  assign timer_cfg_ok = line_cfg[0].on && line_cfg[1].on
                        && line_cfg[0].select == `FEAT_LINE_TIMER
                        && line_cfg[1].select == `FEAT_LINE_TIMER;
  // any config write or read-and-clear on either timed line restarts the measurement
  assign timer_rearm  = (line_wr && req_line < `NUM_TIMED && req_field <= `FLD_POLARITY)
                        || (reg_req.rd && line_hit && req_line < `NUM_TIMED
                            && req_field == `FLD_READ_CLEAR);
  assign first_edge   = line_cfg[0].rising ? rise[0] : fall[0];
  assign second_edge  = line_cfg[1].rising ? rise[1] : fall[1];
  // picks above two name no source, so the count never advances
  assign src_valid    = line_cfg[0].pick < 3'h3;
  assign src_idx      = line_cfg[0].pick[1:0];
  assign src_tick     = src_valid && tick[src_idx];
  assign next_count   = (tick_wrap[src_idx] != 32'h0 && timer_count + 32'h1 == tick_wrap[src_idx])
                        ? 32'h0 : timer_count + 32'h1;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timer_state  <= TIMER_OFF;
      timer_count  <= 32'h0;
      timer_result <= 32'h0;
    end else if (!timer_cfg_ok) begin
      timer_state  <= TIMER_OFF;
      timer_result <= 32'h0;
    end else if (timer_rearm) begin
      timer_state  <= TIMER_WAIT_FIRST;
      timer_result <= 32'h0;
    end else begin
      case (timer_state)
        TIMER_OFF: begin
          timer_state <= TIMER_WAIT_FIRST;
        end
        TIMER_WAIT_FIRST: begin
          // edges on the second line are ignored until the first line fires
          if (first_edge) begin
            timer_state <= TIMER_WAIT_SECOND;
            timer_count <= 32'h0;
          end
        end
        TIMER_WAIT_SECOND: begin
          if (second_edge) begin
            timer_state  <= TIMER_DONE;
            // a tick landing with the second edge still belongs to the interval
            timer_result <= src_tick ? next_count : timer_count;
          end else if (src_tick) begin
            timer_count <= next_count;
          end
        end
        TIMER_DONE: begin
          timer_state <= TIMER_DONE;
        end
        default: begin
          timer_state <= TIMER_OFF;
        end
      endcase
    end
  end

  // seconds in Q16.16: ticks times divisor over the core rate
  logic [63:0] sec_prod;
  assign sec_prod      = ({32'h0, timer_result} * {55'h0, eff_div[src_idx]}) * `SEC_SCALE;
  assign timer_seconds = src_valid ? sec_prod[63:32] : 32'h0;

  // counters: lines 2..5 hardware, line 6 firmware-serviced
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      cnt_en[k]      = line_cfg[k + 2].on && line_cfg[k + 2].select == `FEAT_HW_COUNT;
      tally_clear[k] = reg_req.rd && line_hit && req_field == `FLD_READ_CLEAR
                       && req_line == 4'(k + 2);
    end
    // second counter is lent to tick sources zero and two, fourth to streaming
    cnt_en[1] = cnt_en[1] && !tick_on[0] && !tick_on[2];
    cnt_en[3] = cnt_en[3] && !stream_active;
    cnt_en[4] = line_cfg[6].on && line_cfg[6].select == `FEAT_FW_COUNT;
  end

  generate
    for (gi = 0; gi < 5; gi++) begin : g_tally
      edge_tally u_tally (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .enable  (cnt_en[gi]),
        .rise    (rise[gi + 2]),
        .clear   (tally_clear[gi]),
        .count   (counts[gi])
      );
    end
  endgenerate

  // system timer advances on every second core clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sys_phase <= 1'b0;
      sys_timer <= 32'h0;
    end else begin
      sys_phase <= ~sys_phase;
      if (sys_phase) begin
        sys_timer <= sys_timer + 32'h1;
      end
    end
  end

  // read data
  logic [31:0] full_result;
  logic [31:0] next_rdata;
  logic        next_err;

  always_comb begin
    if (req_line < `NUM_TIMED) begin
      full_result = (line_cfg[req_line[2:0]].select == `FEAT_LINE_TIMER)
                    ? timer_result : 32'h0;
    end else if (req_line < `NUM_LINES) begin
      full_result = counts[3'(req_line - 4'h2)];
    end else begin
      full_result = 32'h0;
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    if (line_hit) begin
      case (req_field)
        `FLD_ON:         next_rdata = {31'h0, line_cfg[req_line[2:0]].on};
        `FLD_SELECT:     next_rdata = line_cfg[req_line[2:0]].select;
        `FLD_CLOCK_PICK: next_rdata = {29'h0, line_cfg[req_line[2:0]].pick};
        `FLD_POLARITY:   next_rdata = {31'h0, line_cfg[req_line[2:0]].rising};
        `FLD_TICKS, `FLD_READ_CLEAR:
          next_rdata = reg_req.stream ? {16'h0, full_result[15:0]} : full_result;
        `FLD_SECONDS:
          next_rdata = (req_line < `NUM_TIMED) ? timer_seconds : 32'h0;
        default:         next_rdata = 32'h0;
      endcase
    end else if (tick_hit) begin
      case (reg_req.addr[1:0])
        `TFLD_DIVIDER: next_rdata = {23'h0, tick_div[req_src]};
        `TFLD_WRAP:    next_rdata = tick_wrap[req_src];
        `TFLD_ON:      next_rdata = {31'h0, tick_on[req_src]};
        default:       next_rdata = 32'h0;
      endcase
    end else if (reg_req.addr == `STREAM_HI_ADDR) begin
      next_rdata = stream_hi;
    end else if (reg_req.addr == `SYS_TIMER_ADDR) begin
      next_rdata = sys_timer;
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.ack   <= reg_req.rd || reg_req.wr;
      reg_rsp.err   <= (reg_req.rd || reg_req.wr) && next_err;
      reg_rsp.rdata <= reg_req.rd ? next_rdata : 32'h0;
    end
  end

  // high half of a stream sample, kept for a later slot of the same scan
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stream_hi <= 32'h0;
    end else if (rd_result && reg_req.stream) begin
      stream_hi <= {16'h0, full_result[31:16]};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_result_zero;
    (timer_state != TIMER_DONE) |-> (timer_result == 32'h0);
  endproperty
  a_result_zero: assert property (p_result_zero)
    else $error("timer result nonzero before the edge pair");

  property p_same_value;
    (reg_req.rd && line_hit && req_line == 4'h1 && req_field == `FLD_TICKS && !reg_req.stream
     && line_cfg[1].select == `FEAT_LINE_TIMER)
      |=> (reg_rsp.rdata == $past(timer_result));
  endproperty
  a_same_value: assert property (p_same_value)
    else $error("second timed line returned a different interval");

  property p_read_clear;
    (reg_req.rd && line_hit && req_line == 4'h0 && req_field == `FLD_READ_CLEAR
     && !reg_req.stream && timer_cfg_ok)
      |=> (reg_rsp.rdata == $past(timer_result)) && (timer_result == 32'h0)
          && (timer_state == TIMER_WAIT_FIRST);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("timer read-and-clear did not return, clear and rearm");

  property p_order;
    (timer_state == TIMER_WAIT_FIRST && !first_edge && !timer_rearm && timer_cfg_ok)
      |=> (timer_state == TIMER_WAIT_FIRST);
  endproperty
  a_order: assert property (p_order)
    else $error("timer left first wait without a first-line edge");

  property p_capture;
    (timer_state == TIMER_WAIT_SECOND && second_edge && !timer_rearm && timer_cfg_ok)
      |=> (timer_state == TIMER_DONE)
          && (timer_result == ($past(src_tick) ? $past(next_count) : $past(timer_count)));
  endproperty
  a_capture: assert property (p_capture)
    else $error("second-line edge not captured");

  property p_one_shot;
    (timer_state == TIMER_DONE && !timer_rearm && timer_cfg_ok)
      |=> (timer_state == TIMER_DONE) && $stable(timer_result);
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("timer measured again without rearm");

  property p_falling_pick;
    (timer_state == TIMER_WAIT_FIRST && !line_cfg[0].rising && rise[0] && !fall[0]
     && !timer_rearm && timer_cfg_ok)
      |=> (timer_state == TIMER_WAIT_FIRST);
  endproperty
  a_falling_pick: assert property (p_falling_pick)
    else $error("rising edge accepted while falling edge selected");

  property p_off;
    (!line_cfg[0].on || !line_cfg[1].on) |=> (timer_state == TIMER_OFF);
  endproperty
  a_off: assert property (p_off)
    else $error("timer active while a timed line is off");

  property p_shared_counter;
    (tick_on[0] && !tally_clear[1]) |=> $stable(counts[1]);
  endproperty
  a_shared_counter: assert property (p_shared_counter)
    else $error("second counter moved while tick source zero runs");

  property p_stream_half;
    (rd_result && reg_req.stream) |=> (reg_rsp.rdata[31:16] == 16'h0)
      && (stream_hi[15:0] == $past(full_result[31:16]));
  endproperty
  a_stream_half: assert property (p_stream_half)
    else $error("stream read not split into low half and captured high half");

  property p_sys_rate;
    sys_phase |=> (sys_timer == $past(sys_timer) + 32'h1) ##1 $stable(sys_timer);
  endproperty
  a_sys_rate: assert property (p_sys_rate)
    else $error("system timer not running at half the core rate");

endmodule : edge_counters_and_line_timer
`default_nettype wire

/* bench/edge_source.sv */
// partner model: drives one clean pulse per request on counter lines
`timescale 1ns/1ps
`default_nettype none
module edge_source (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // pulse request per line
  input  wire logic [4:0] pulse_req,
  output logic      [4:0] lines
);
  logic [3:0] cnt [5];

  // high 3 cycles, low at least 6, so the two-flop sampler sees every edge
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lines <= 5'h00;
      for (int i = 0; i < 5; i++) cnt[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (cnt[i] != 4'h0) begin
          cnt[i]   <= cnt[i] - 4'h1;
          lines[i] <= (cnt[i] > 4'h6);
        end else if (pulse_req[i]) begin
          cnt[i]   <= 4'h8;
          lines[i] <= 1'b1;
        end
      end
    end
  end
endmodule : edge_source
`default_nettype wire

/* bench/edge_counters_and_line_timer_test.sv */
// self-checking bench for the edge counters and line timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("FAIL %0t got %h expected %h", $time, got, exp); end end
module edge_counters_and_line_timer_test import edge_timing_pkg::*;;
  logic        ref_clk;
  logic        resetn;
  reg_req_s    req;
  reg_rsp_s    rsp;
  logic        first_l;
  logic        second_l;
  logic        stream_act;
  logic [4:0]  preq;
  logic [4:0]  src_lines;
  logic [31:0] rd;
  logic        er;
  logic [31:0] t0;
  logic [31:0] model [5];
  logic [31:0] m;
  logic        tick_on;
  logic        off0;
  int          n_errors;
  int          num_checks;
  int          cycles;
  int          seed;

  edge_counters_and_line_timer edge_counters_and_line_timer_i (
    .ref_clk(ref_clk), .resetn(resetn), .reg_req(req), .reg_rsp(rsp),
    .first_timed_line(first_l), .second_timed_line(second_l),
    .hw_count_lines(src_lines[3:0]), .free_counter_pin(src_lines[4]),
    .stream_active(stream_act));
  edge_source edge_source_i (
    .ref_clk(ref_clk), .resetn(resetn), .pulse_req(preq), .lines(src_lines));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      finish_test();
    end
  end

  function automatic logic [15:0] la(input int l, input int f);
    return 16'(32'h2000 + l * 16 + f);
  endfunction : la

  // one access; answer sampled just after the edge that takes it
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic s);
    @(posedge ref_clk);
    req <= '{rd: !w, wr: w, stream: s, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
    #1;
    rd = rsp.rdata;
    er = rsp.err;
  endtask : acc

  task wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 1'b0);
  endtask : wr

  task rdv(input logic [15:0] a);
    acc(1'b0, a, 32'h0, 1'b0);
  endtask : rdv

  task measure(input logic p, input int d);
    @(posedge ref_clk);
    first_l  <= !p;
    second_l <= !p;
    wr(la(0, 3), {31'h0, p});
    wr(la(1, 3), {31'h0, p});
    rdv(la(0, 4));
    `CHK(rd, 32'h0)
    @(posedge ref_clk) second_l <= p;
    repeat (6) @(posedge ref_clk);
    second_l <= !p;
    repeat (6) @(posedge ref_clk);
    first_l <= p;
    repeat (d) @(posedge ref_clk);
    second_l <= p;
    repeat (8) @(posedge ref_clk);
    rdv(la(0, 4));
    `CHK(rd, 32'(d))
    acc(1'b0, la(0, 4), 32'h0, 1'b1);
    `CHK(rd, 32'(d) & 32'h0000FFFF)
    rdv(16'h2200);
    `CHK(rd, 32'(d) >> 16)
    rdv(la(1, 4));
    `CHK(rd, 32'(d))
    rdv(la(0, 5));
    `CHK(rd, 32'((longint'(d) * 65536) / 200000000))
    // a second full edge pair must not start another measurement
    @(posedge ref_clk);
    first_l  <= !p;
    second_l <= !p;
    repeat (6) @(posedge ref_clk);
    first_l <= p;
    repeat (6) @(posedge ref_clk);
    second_l <= p;
    repeat (8) @(posedge ref_clk);
    rdv(la(1, 4));
    `CHK(rd, 32'(d))
    rdv(la(0, 6));
    `CHK(rd, 32'(d))
    // edge of the wrong direction on the first line must not start a measurement
    @(posedge ref_clk) first_l <= !p;
    repeat (6) @(posedge ref_clk);
    rdv(la(0, 4));
    `CHK(rd, 32'h0)
  endtask : measure

  task count_phase;
    repeat (6) begin
      m = $random(seed);
      @(posedge ref_clk) preq <= m[4:0];
      @(posedge ref_clk) preq <= 5'h00;
      repeat (12) @(posedge ref_clk);
      for (int i = 0; i < 5; i++)
        if (m[i] && !(i == 0 && off0) && !(i == 1 && tick_on) && !(i == 3 && stream_act))
          model[i]++;
    end
    for (int i = 0; i < 5; i++) begin
      rdv(la(2 + i, 4));
      `CHK(rd, model[i])
    end
  endtask : count_phase

  initial begin
    seed = 32'hbe6059af;
    req = '0;
    first_l = 1'b1;
    second_l = 1'b1;
    stream_act = 1'b1;
    preq = 5'h00;
    resetn = 1'b0;
    tick_on = 1'b0;
    off0 = 1'b0;
    for (int i = 0; i < 5; i++) model[i] = 32'h0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    rdv(la(0, 1));
    `CHK(rd, 32'h0)
    rdv(16'h3000);
    `CHK(er, 1'b1)
    // counters are enabled while all three tick sources are still off
    for (int i = 0; i < 5; i++) begin
      wr(la(2 + i, 1), (i == 4) ? 32'h8 : 32'h7);
      wr(la(2 + i, 0), 32'h1);
    end
    wr(16'h2100, 32'h0);
    wr(16'h2102, 32'h1);
    tick_on = 1'b1;
    for (int l = 0; l < 2; l++) begin
      wr(la(l, 1), 32'h6);
      wr(la(l, 2), 32'h0);
      wr(la(l, 0), 32'h1);
    end
    measure(1'b0, 10);
    measure(1'b1, 65536 + ($random(seed) & 511));
    rdv(16'hF050);
    t0 = rd;
    repeat (98) @(posedge ref_clk);
    rdv(16'hF050);
    `CHK(rd - t0, 32'd50)
    count_phase();
    wr(16'h2102, 32'h0);
    tick_on = 1'b0;
    @(posedge ref_clk) stream_act <= 1'b0;
    count_phase();
    rdv(la(4, 6));
    `CHK(rd, model[2])
    rdv(la(4, 4));
    `CHK(rd, 32'h0)
    model[2] = 32'h0;
    acc(1'b0, la(2, 4), 32'h0, 1'b1);
    `CHK(rd, model[0] & 32'h0000FFFF)
    rdv(16'h2200);
    `CHK(rd, model[0] >> 16)
    wr(la(2, 0), 32'h0);
    off0 = 1'b1;
    // tick source two alone must also hold the second counter
    wr(16'h210A, 32'h1);
    tick_on = 1'b1;
    count_phase();
    finish_test();
  end
endmodule : edge_counters_and_line_timer_test
`default_nettype wire
